// File: core/etsc_capture.sv
`timescale 1ns/1ps
`include "etsc_regs.svh"


module etsc_capture
    import etsc_pkg::*;
#(
    parameter int ADDR_W = 11
)
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         event_pin,
    input  wire etsc_time_t   ptp_time,
    input  wire logic [15:0]  unit_cfg,
    input  wire logic         rearm,
    input  wire etsc_rd_req_t rd_req,
    output logic [15:0]       rd_data_ff,
    output logic              rd_valid_ff,
    output logic [1:0]        captured_ff
);

    // The decode below is written for the fixed 11-bit offset space.
    if (ADDR_W != 11) begin : g_addr_w_check
        $error("etsc_capture serves an 11-bit register address only");
    end

    logic         pin_prev_ff;
    logic         seen_ff;
    logic         nxt_pin_prev;
    logic         nxt_seen;
    logic [1:0]   nxt_captured;
    logic         rise_evt;
    logic         fall_evt;
    logic         evt_take;
    logic         load_first;
    logic         load_second;
    logic [1:0]   count_base;
    etsc_sample_t new_sample;
    etsc_sample_t s1_ff;
    etsc_sample_t s2_ff;
    logic [15:0]  rd_mux;
    logic [15:0]  nxt_rd_data;

    // The first edge after reset only primes the history, so a pin that
    // idles high is not mistaken for a rising edge.
    assign nxt_pin_prev = event_pin;
    assign nxt_seen     = 1'b1;
    assign rise_evt     = seen_ff & event_pin & ~pin_prev_ff;
    assign fall_evt     = seen_ff & ~event_pin & pin_prev_ff;
    assign evt_take     = (rise_evt & unit_cfg[`ETSC_CFG_RISE_BIT]) |
                          (fall_evt & unit_cfg[`ETSC_CFG_FALL_BIT]);

    // A rearm in the same cycle as an event restarts the count with that
    // event as the first sample, so the event is never lost.
    assign count_base  = rearm ? 2'd0 : captured_ff;
    assign load_first  = evt_take & (count_base == 2'd0);
    assign load_second = evt_take & (count_base == 2'd1);
    assign nxt_captured = (evt_take && count_base != 2'd2) ?
                          count_base + 2'd1 : count_base;

    // One struct from one input port gives every field the same instant.
    assign new_sample = '{t: ptp_time, rising: rise_evt};

    etsc_sample_store u_first (
        .clk       (clk),
        .resetn    (resetn),
        .load      (load_first),
        .sample_in (new_sample),
        .sample_ff (s1_ff)
    );

    etsc_sample_store u_second (
        .clk       (clk),
        .resetn    (resetn),
        .load      (load_second),
        .sample_in (new_sample),
        .sample_ff (s2_ff)
    );

    // Read decode; unmapped and reserved offsets read as zero.
    always_comb begin
        unique case (rd_req.addr)
            `ETSC_S1_NSL: rd_mux = s1_ff.t.ns[15:0];
            `ETSC_S1_NSH: rd_mux = {1'b0, s1_ff.rising,
                                    s1_ff.t.ns[29:16]};
            `ETSC_S1_SL:  rd_mux = s1_ff.t.sec[15:0];
            `ETSC_S1_SH:  rd_mux = s1_ff.t.sec[31:16];
            `ETSC_S1_SUB: rd_mux = {13'h0000, s1_ff.t.sub};
            `ETSC_S2_NSL: rd_mux = s2_ff.t.ns[15:0];
            `ETSC_S2_NSH: rd_mux = {1'b0, s2_ff.rising,
                                    s2_ff.t.ns[29:16]};
            `ETSC_S2_SL:  rd_mux = s2_ff.t.sec[15:0];
            `ETSC_S2_SH:  rd_mux = s2_ff.t.sec[31:16];
            `ETSC_S2_SUB: rd_mux = {13'h0000, s2_ff.t.sub};
            default:      rd_mux = `ETSC_REG_RESET;
        endcase
    end

    // Data is held between reads so a slow host may sample it late.
    assign nxt_rd_data = rd_req.rd ? rd_mux : rd_data_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pin_prev_ff <= 1'b0;
            seen_ff     <= 1'b0;
            captured_ff <= 2'd0;
            rd_data_ff  <= `ETSC_REG_RESET;
            rd_valid_ff <= 1'b0;
        end else begin
            pin_prev_ff <= nxt_pin_prev;
            seen_ff     <= nxt_seen;
            captured_ff <= nxt_captured;
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= rd_req.rd;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_first_ns_low: assert property (
        load_first |=> s1_ff.t.ns[15:0] == $past(ptp_time.ns[15:0]))
        else $error("first sample ns low not captured");

    a_nsh_layout: assert property (
        rd_req.rd && rd_req.addr == `ETSC_S1_NSH
        |=> rd_data_ff[13:0] == $past(s1_ff.t.ns[29:16])
            && !rd_data_ff[15])
        else $error("ns high word layout wrong");

    a_edge_bit: assert property (
        load_first |=> s1_ff.rising == $past(event_pin))
        else $error("edge indication wrong");

    a_sec_split: assert property (
        rd_req.rd && rd_req.addr == `ETSC_S1_SH
        |=> rd_data_ff == $past(s1_ff.t.sec[31:16]))
        else $error("seconds high word wrong");

    a_sub_slot: assert property (
        rd_req.rd && rd_req.addr == `ETSC_S1_SUB
        |=> rd_data_ff[15:3] == 13'h0000
            && rd_data_ff[2:0] == $past(s1_ff.t.sub))
        else $error("sub slot field wrong");

    a_second_set: assert property (
        load_second |=> s2_ff.t == $past(ptp_time) && $stable(s1_ff))
        else $error("second sample not captured alone");

    a_rise_gate: assert property (
        rise_evt && !unit_cfg[`ETSC_CFG_RISE_BIT] && !rearm
        |=> $stable(captured_ff))
        else $error("disabled rising edge captured");

    a_fall_gate: assert property (
        fall_evt && !unit_cfg[`ETSC_CFG_FALL_BIT] && !rearm
        |=> $stable(captured_ff))
        else $error("disabled falling edge captured");

    a_coherent_time: assert property (
        load_first |=> s1_ff.t == $past(ptp_time) ##1 $stable(s1_ff.t)
        || $past(load_first))
        else $error("first sample fields not coherent");

    a_nsh2_layout: assert property (
        rd_req.rd && rd_req.addr == `ETSC_S2_NSH
        |=> rd_data_ff == {1'b0, $past(s2_ff.rising),
                           $past(s2_ff.t.ns[29:16])})
        else $error("second ns high word layout wrong");

    a_unmapped_zero: assert property (
        rd_req.rd && rd_req.addr == (`ETSC_S1_SUB + 11'h002)
        |=> rd_data_ff == `ETSC_REG_RESET)
        else $error("reserved offset not read as zero");

    a_read_valid: assert property (
        rd_valid_ff == $past(rd_req.rd))
        else $error("read valid not one cycle after read");

    a_read_hold: assert property (
        !rd_req.rd |=> $stable(rd_data_ff))
        else $error("read data changed without a read");

    a_first_hold: assert property (
        !load_first |=> $stable(s1_ff))
        else $error("first sample changed without an event");

    a_second_hold: assert property (
        !load_second |=> $stable(s2_ff))
        else $error("second sample changed without an event");

    a_count_sat: assert property (
        captured_ff == 2'd2 && !rearm |=> captured_ff == 2'd2)
        else $error("third event taken without rearm");

    a_rearm_first: assert property (
        rearm && evt_take |=> captured_ff == 2'd1 && $stable(s2_ff))
        else $error("event at rearm not taken as first sample");

    c_two_events: cover property (load_first ##[1:20] load_second);
    c_back_to_back: cover property (load_first ##1 load_second);
    c_falling_cap: cover property (load_first && fall_evt);
    c_third_ignored: cover property (captured_ff == 2'd2 && evt_take);
    c_rearm_event: cover property (rearm && evt_take);

endmodule : etsc_capture

// File: core/etsc_regs.svh
`ifndef ETSC_REGS_SVH
`define ETSC_REGS_SVH

// Byte offsets of the capture registers, one 16-bit register per offset.
`define ETSC_S1_NSL      11'h424
`define ETSC_S1_NSH      11'h426
`define ETSC_S1_SL       11'h428
`define ETSC_S1_SH       11'h42a
`define ETSC_S1_SUB      11'h42c
`define ETSC_S2_NSL      11'h434
`define ETSC_S2_NSH      11'h436
`define ETSC_S2_SL       11'h438
`define ETSC_S2_SH       11'h43a
`define ETSC_S2_SUB      11'h43c

// Field positions.
`define ETSC_NSH_EDGE_BIT  14
`define ETSC_CFG_RISE_BIT  7
`define ETSC_CFG_FALL_BIT  6

// Reset value of every capture register.
`define ETSC_REG_RESET   16'h0000

// Samples held by the unit.
`define ETSC_SAMPLES     2

`endif

// File: core/etsc_pkg.sv
package etsc_pkg;

    typedef struct packed {
        logic [31:0] sec;
        logic [29:0] ns;
        logic [2:0]  sub;
    } etsc_time_t;

    typedef struct packed {
        etsc_time_t  t;
        logic        rising;
    } etsc_sample_t;

    typedef struct packed {
        logic        rd;
        logic [10:0] addr;
    } etsc_rd_req_t;

endpackage : etsc_pkg

// File: core/etsc_sample_store.sv
`timescale 1ns/1ps
`include "etsc_regs.svh"

module etsc_sample_store
    import etsc_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire etsc_sample_t sample_in,
    output etsc_sample_t      sample_ff
);

    etsc_sample_t nxt_sample;

    // The whole sample is taken in one edge so its fields never mix events.
    assign nxt_sample = load ? sample_in : sample_ff;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sample_ff <= '0;
        end else begin
            sample_ff <= nxt_sample;
        end
    end

endmodule : etsc_sample_store

// File: verif/etsc_event_src.sv
`timescale 1ns/1ps

// Far-side signal source on the selected pin. The pin is modelled as
// already synchronous to clk, so it shows clean levels with no glitches.
module etsc_event_src (
    input  wire logic level_req,
    output logic      event_pin
);
    assign event_pin = level_req;
endmodule : etsc_event_src

// File: verif/tb_etsc_capture.sv
`timescale 1ns/1ps
`include "etsc_regs.svh"

module tb_etsc_capture
    import etsc_pkg::*;
;
    logic         clk;
    logic         resetn;
    logic         level_req;
    logic         event_pin;
    logic         rearm;
    etsc_time_t   ptp_time;
    logic [15:0]  unit_cfg;
    etsc_rd_req_t rd_req;
    logic [15:0]  rd_data_ff;
    logic         rd_valid_ff;
    logic [1:0]   captured_ff;
    int           err_total;
    int           checked;
    etsc_time_t   t1;
    etsc_time_t   t2;
    etsc_time_t   t3;

    etsc_event_src src (.level_req(level_req), .event_pin(event_pin));

    etsc_capture #(.ADDR_W(11)) dut (
        .clk(clk), .resetn(resetn), .event_pin(event_pin),
        .ptp_time(ptp_time), .unit_cfg(unit_cfg), .rearm(rearm),
        .rd_req(rd_req), .rd_data_ff(rd_data_ff),
        .rd_valid_ff(rd_valid_ff), .captured_ff(captured_ff)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic results;
        if (err_total == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd(input logic [10:0] a, input logic [15:0] exp);
        @(posedge clk) #10 rd_req = '{rd: 1'b1, addr: a};
        @(posedge clk) #10 rd_req = '{rd: 1'b0, addr: a};
        chk({15'h0000, rd_valid_ff}, 16'h0001);
        chk(rd_data_ff, exp);
    endtask : rd

    // The time changes right after the capturing edge, so a sample built
    // from mixed instants shows up as wrong fields.
    task automatic ev(input logic lvl, input etsc_time_t t);
        @(posedge clk) #10 ptp_time = t;
        level_req = lvl;
        @(posedge clk) #10 ptp_time = ~t;
    endtask : ev

    task automatic chk_set(input logic [10:0] b, input etsc_time_t t,
                           input logic r);
        rd(b, t.ns[15:0]);
        rd(b + 11'h002, {1'b0, r, t.ns[29:16]});
        rd(b + 11'h004, t.sec[15:0]);
        rd(b + 11'h006, t.sec[31:16]);
        rd(b + 11'h008, {13'h0000, t.sub});
    endtask : chk_set

    task automatic cnt(input logic [1:0] exp);
        chk({14'h0000, captured_ff}, {14'h0000, exp});
    endtask : cnt

    initial begin
        #200000;
        err_total++;
        results();
    end

    initial begin
        resetn = 1'b0;
        level_req = 1'b0;
        rearm = 1'b0;
        unit_cfg = 16'h0080;
        ptp_time = '0;
        rd_req = '0;
        err_total = 0;
        checked = 0;
        t1 = '{sec: 32'h89ab_cdef, ns: 30'h2bcd_1234, sub: 3'h4};
        t2 = '{sec: 32'h1357_9bdf, ns: 30'h1a5a_5a5a, sub: 3'h3};
        t3 = '{sec: 32'h0f0f_f0f0, ns: 30'h3fff_fff8, sub: 3'h0};
        repeat (3) @(posedge clk);
        #10 resetn = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(11'h424 + 11'(2 * i), 16'h0000);
            rd(11'h434 + 11'(2 * i), 16'h0000);
        end
        rd(11'h42e, 16'h0000);
        ev(1'b1, t1);
        cnt(2'h1);
        ev(1'b0, t3);
        cnt(2'h1);
        @(posedge clk) #10 unit_cfg = 16'h0040;
        ev(1'b1, t3);
        cnt(2'h1);
        ev(1'b0, t2);
        cnt(2'h2);
        chk_set(`ETSC_S1_NSL, t1, 1'b1);
        chk_set(`ETSC_S2_NSL, t2, 1'b0);
        @(posedge clk) #10 unit_cfg = 16'h00c0;
        ev(1'b1, t3);
        cnt(2'h2);
        rd(`ETSC_S1_NSL, t1.ns[15:0]);
        @(posedge clk) #10 rearm = 1'b1;
        @(posedge clk) #10 rearm = 1'b0;
        cnt(2'h0);
        ev(1'b0, t3);
        cnt(2'h1);
        chk_set(`ETSC_S1_NSL, t3, 1'b0);
        rd(`ETSC_S2_SH, t2.sec[31:16]);
        @(posedge clk) #10 ptp_time = t2;
        level_req = 1'b1;
        rearm = 1'b1;
        @(posedge clk) #10 ptp_time = ~t2;
        rearm = 1'b0;
        cnt(2'h1);
        chk_set(`ETSC_S1_NSL, t2, 1'b1);
        results();
    end
endmodule : tb_etsc_capture
